// *** pkg/mgp_defs.vh ***
// constants for the three multiplexed general-purpose ports
// assumes an 8-bit register port and a single core clock
`ifndef MGP_DEFS_VH
`define MGP_DEFS_VH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define MGP_OFF_F_DIR 8'h00
`define MGP_OFF_F_PIN 8'h01
`define MGP_OFF_F_LAT 8'h02
`define MGP_OFF_G_DIR 8'h03
`define MGP_OFF_G_PIN 8'h04
`define MGP_OFF_G_LAT 8'h05
`define MGP_OFF_H_DIR 8'h06
`define MGP_OFF_H_PIN 8'h07
`define MGP_OFF_H_LAT 8'h08
`define MGP_OFF_ACFG 8'h09
`define MGP_OFF_CMP 8'h0a
`define MGP_OFF_CIO 8'h0b

// ----------------------------------------
// reset values
// ----------------------------------------
`define MGP_DIR_RST_F 8'hff
`define MGP_DIR_RST_G 5'h1f
`define MGP_DIR_RST_H 8'hff
`define MGP_LAT_RST_F 8'h00
`define MGP_LAT_RST_G 5'h00
`define MGP_LAT_RST_H 8'h00
`define MGP_ACFG_RST 6'h00
`define MGP_CMP_RST 6'h00
`define MGP_CIO_RST 4'h0
`define MGP_RD_NONE 8'h00

// ----------------------------------------
// field positions and codes
// ----------------------------------------
`define MGP_PCFG_ALL_DIG 4'hf
`define MGP_PCFG_MAX 5'h0f
`define MGP_CMP_OFF 3'h7
`define MGP_CMP_OUT_MODE 3'h3
`define MGP_CIO_TX1SRC 3
`define MGP_CIO_TX1EN 2
`define MGP_AN_F_BASE 5
`define MGP_AN_H_BASE 12
`define MGP_G_TX 0
`define MGP_G_TX1 1
`define MGP_G_RX 2
`define MGP_F_C2 1
`define MGP_F_C1 2
`define MGP_F_REF 5

`endif

// *** hdl/mgp_ports.v ***
// three general-purpose ports with direction, pin and latch registers
// assumes pin inputs already synchronous to clock and a simple register port
// with read data one cycle after the read strobe

`include "mgp_defs.vh"

// Overview of operation
// - direction one: second-port pin floats as input
// - direction zero: second-port pin drives latch
// - latch register reads latch, not pins
// - second port has exactly five pins
// - low three second-port pins shared with CAN
// - second-port bit 0 carries CAN transmit
// - bit 1 carries complement transmit or bit clock
// - bit 2 passes pin level to CAN receive
// - pin register reads pins, writes latch
// - latch register readable and writable
// - every reset sets all direction bits
// - latches cleared only on power-on reset
// - first-port bits 1,2 give comparator outputs
// - first-port bit 5 gives comparator reference
// - third-port bits 4-7 are analog 12-15
// - after power-on, low seven first-port pins analog
module mgp_ports #(
   parameter F_W = 8,
   parameter G_W = 5,
   parameter H_W = 8
) (
   // clock and resets
   input wire clock,
   input wire rst_b,
   input wire por_b,
   // register port
   input wire [7:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output wire [7:0] reg_rdata,
   // first port pins
   input wire [F_W-1:0] f_pin_in,
   output wire [F_W-1:0] f_pin_out,
   output wire [F_W-1:0] f_pin_oe,
   // second port pins
   input wire [G_W-1:0] g_pin_in,
   output wire [G_W-1:0] g_pin_out,
   output wire [G_W-1:0] g_pin_oe,
   // third port pins
   input wire [H_W-1:0] h_pin_in,
   output wire [H_W-1:0] h_pin_out,
   output wire [H_W-1:0] h_pin_oe,
   // comparator side
   input wire comparator_one_result,
   input wire comparator_two_result,
   input wire comparator_reference_out,
   output wire [2:0] comparator_mode,
   output wire [5:0] analog_config_out,
   // can side
   input wire can_enable,
   input wire can_transmit_out,
   input wire can_complement_transmit_out,
   input wire can_bit_clock,
   output wire can_receive_in,
   output wire [3:0] can_pin_control_out
);

   // ----------------------------------------
   // registers
   // ----------------------------------------
   reg [F_W-1:0] f_dir_q;
   reg [G_W-1:0] g_dir_q;
   reg [H_W-1:0] h_dir_q;
   reg [F_W-1:0] f_lat_q;
   reg [G_W-1:0] g_lat_q;
   reg [H_W-1:0] h_lat_q;
   reg [5:0] acfg_q;
   reg [5:0] cmp_q;
   reg [3:0] cio_q;
   reg [7:0] rdata_q;
   reg [7:0] rdata_d;
   reg [F_W-1:0] f_dir_d;
   reg [G_W-1:0] g_dir_d;
   reg [H_W-1:0] h_dir_d;
   reg [F_W-1:0] f_lat_d;
   reg [G_W-1:0] g_lat_d;
   reg [H_W-1:0] h_lat_d;
   reg [5:0] acfg_d;
   reg [5:0] cmp_d;
   reg [3:0] cio_d;

   wire any_rst_b;
   wire [3:0] pcfg;
   wire cmp_on;
   wire cmp_out;
   wire tx1_en;
   wire tx1_sel;
   wire [F_W-1:0] f_analog;
   wire [H_W-1:0] h_analog;
   wire [F_W-1:0] f_digital_in;
   wire [H_W-1:0] h_digital_in;
   wire [F_W-1:0] f_own;
   wire [F_W-1:0] f_alt;
   wire [G_W-1:0] g_own;
   wire [G_W-1:0] g_alt;
   wire [G_W-1:0] g_hold_in;

   // power-on also counts as a reset for the control registers
   assign any_rst_b = rst_b & por_b;

   // ----------------------------------------
   // write decode
   // ----------------------------------------
   // pins and latch offsets share one latch, so both decode to one enable
   wire wr_f_dir;
   wire wr_f_lat;
   wire wr_g_dir;
   wire wr_g_lat;
   wire wr_h_dir;
   wire wr_h_lat;
   wire wr_acfg;
   wire wr_cmp;
   wire wr_cio;

   assign wr_f_dir = reg_wr & (reg_addr == `MGP_OFF_F_DIR);
   assign wr_f_lat = reg_wr &
      ((reg_addr == `MGP_OFF_F_PIN) | (reg_addr == `MGP_OFF_F_LAT));
   assign wr_g_dir = reg_wr & (reg_addr == `MGP_OFF_G_DIR);
   assign wr_g_lat = reg_wr &
      ((reg_addr == `MGP_OFF_G_PIN) | (reg_addr == `MGP_OFF_G_LAT));
   assign wr_h_dir = reg_wr & (reg_addr == `MGP_OFF_H_DIR);
   assign wr_h_lat = reg_wr &
      ((reg_addr == `MGP_OFF_H_PIN) | (reg_addr == `MGP_OFF_H_LAT));
   assign wr_acfg = reg_wr & (reg_addr == `MGP_OFF_ACFG);
   assign wr_cmp = reg_wr & (reg_addr == `MGP_OFF_CMP);
   assign wr_cio = reg_wr & (reg_addr == `MGP_OFF_CIO);

   // ----------------------------------------
   // next register values
   // ----------------------------------------
   // unmapped offsets and read-only bits fall through and keep the old value
   always @*
   begin
      f_dir_d = f_dir_q;
      g_dir_d = g_dir_q;
      h_dir_d = h_dir_q;
      f_lat_d = f_lat_q;
      g_lat_d = g_lat_q;
      h_lat_d = h_lat_q;
      acfg_d = acfg_q;
      cmp_d = cmp_q;
      cio_d = cio_q;
      if (wr_f_dir)
      begin
         f_dir_d = reg_wdata[F_W-1:0];
      end
      if (wr_g_dir)
      begin
         g_dir_d = reg_wdata[G_W-1:0];
      end
      if (wr_h_dir)
      begin
         h_dir_d = reg_wdata[H_W-1:0];
      end
      if (wr_f_lat)
      begin
         f_lat_d = reg_wdata[F_W-1:0];
      end
      if (wr_g_lat)
      begin
         g_lat_d = reg_wdata[G_W-1:0];
      end
      if (wr_h_lat)
      begin
         h_lat_d = reg_wdata[H_W-1:0];
      end
      if (wr_acfg)
      begin
         acfg_d = reg_wdata[5:0];
      end
      if (wr_cmp)
      begin
         cmp_d = reg_wdata[5:0];
      end
      if (wr_cio)
      begin
         cio_d = reg_wdata[7:4];
      end
   end

   // ----------------------------------------
   // analog selection
   // ----------------------------------------
   // channel is analog while its number lies inside the configured range;
   // all-digital code leaves every channel digital
   function is_analog;
      input integer ch;
      input [3:0] cfg;
      begin
         is_analog = (cfg != `MGP_PCFG_ALL_DIG) &&
                     (ch <= (`MGP_PCFG_MAX - {1'b0, cfg}));
      end
   endfunction

   assign pcfg = acfg_q[3:0];
   assign cmp_on = (cmp_q[2:0] != `MGP_CMP_OFF);
   assign cmp_out = (cmp_q[2:0] == `MGP_CMP_OUT_MODE);
   assign tx1_en = cio_q[`MGP_CIO_TX1EN];
   assign tx1_sel = cio_q[`MGP_CIO_TX1SRC];

   genvar gi;
   generate
      for (gi = 0; gi < F_W; gi = gi + 1)
      begin : g_f_an
         if (gi < 7)
         begin : g_ch
            // comparator inputs stay analog while comparators are powered
            assign f_analog[gi] =
               is_analog(gi + `MGP_AN_F_BASE, pcfg) |
               (cmp_on && (gi >= 3)) |
               ((gi == `MGP_F_REF) && comparator_reference_out);
         end
         else
         begin : g_dig
            assign f_analog[gi] = 1'b0;
         end
      end
      for (gi = 0; gi < H_W; gi = gi + 1)
      begin : g_h_an
         if (gi >= 4)
         begin : g_ch
            assign h_analog[gi] = is_analog(gi + `MGP_AN_H_BASE - 4, pcfg);
         end
         else
         begin : g_dig
            assign h_analog[gi] = 1'b0;
         end
      end
   endgenerate

   // analog pins read zero on the digital path
   assign f_digital_in = f_pin_in & ~f_analog;
   assign h_digital_in = h_pin_in & ~h_analog;

   // ----------------------------------------
   // first port output mux
   // ----------------------------------------
   // comparator outputs take over bits 1 and 2 in the output mode
   assign f_own = cmp_out ?
      ({{(F_W-3){1'b0}}, 3'b110}) : {F_W{1'b0}};
   assign f_alt = {{(F_W-3){1'b0}}, comparator_one_result,
                   comparator_two_result, 1'b0};

   generate
      for (gi = 0; gi < F_W; gi = gi + 1)
      begin : g_f_pin
         assign f_pin_out[gi] = f_own[gi] ? f_alt[gi] : f_lat_q[gi];
         // a pin owned by a comparator output is driven even if analog
         assign f_pin_oe[gi] = ~f_dir_q[gi] & (f_own[gi] | ~f_analog[gi]);
      end
   endgenerate

   // ----------------------------------------
   // second port output mux
   // ----------------------------------------
   // with CAN on, bit 0 carries transmit and, if its enable bit in cio_q is set, bit 1 the selected
   // secondary source; direction bits still gate the drivers, so software
   // must clear them for the CAN outputs
   assign g_own = {{(G_W-2){1'b0}}, can_enable & tx1_en, can_enable};
   assign g_alt = {{(G_W-2){1'b0}},
                   tx1_sel ? can_bit_clock : can_complement_transmit_out,
                   can_transmit_out};
   // CAN receive pin is held as input while CAN is on
   assign g_hold_in = {{(G_W-3){1'b0}}, can_enable, 2'b00};

   generate
      for (gi = 0; gi < G_W; gi = gi + 1)
      begin : g_g_pin
         assign g_pin_out[gi] = g_own[gi] ? g_alt[gi] : g_lat_q[gi];
         assign g_pin_oe[gi] = ~g_dir_q[gi] & ~g_hold_in[gi];
      end
   endgenerate

   // recessive level while CAN is off
   assign can_receive_in = can_enable ? g_pin_in[`MGP_G_RX] : 1'b1;

   // ----------------------------------------
   // third port output
   // ----------------------------------------
   assign h_pin_out = h_lat_q;
   assign h_pin_oe = ~h_dir_q & ~h_analog;

   // ----------------------------------------
   // direction and control registers
   // ----------------------------------------
   always @(posedge clock or negedge any_rst_b)
   begin
      if (!any_rst_b)
      begin
         f_dir_q <= `MGP_DIR_RST_F;
         g_dir_q <= `MGP_DIR_RST_G;
         h_dir_q <= `MGP_DIR_RST_H;
         acfg_q <= `MGP_ACFG_RST;
         cmp_q <= `MGP_CMP_RST;
         cio_q <= `MGP_CIO_RST;
      end
      else
      begin
         f_dir_q <= f_dir_d;
         g_dir_q <= g_dir_d;
         h_dir_q <= h_dir_d;
         acfg_q <= acfg_d;
         cmp_q <= cmp_d;
         cio_q <= cio_d;
      end
   end

   // ----------------------------------------
   // output latches
   // ----------------------------------------
   // only power-on clears them; other resets leave the latched values as they were
   always @(posedge clock or negedge por_b)
   begin
      if (!por_b)
      begin
         f_lat_q <= `MGP_LAT_RST_F;
         g_lat_q <= `MGP_LAT_RST_G;
         h_lat_q <= `MGP_LAT_RST_H;
      end
      else
      begin
         f_lat_q <= f_lat_d;
         g_lat_q <= g_lat_d;
         h_lat_q <= h_lat_d;
      end
   end

   // ----------------------------------------
   // read path
   // ----------------------------------------
   always @*
   begin
      rdata_d = `MGP_RD_NONE;
      case (reg_addr)
         `MGP_OFF_F_DIR: rdata_d[F_W-1:0] = f_dir_q;
         `MGP_OFF_F_PIN: rdata_d[F_W-1:0] = f_digital_in;
         `MGP_OFF_F_LAT: rdata_d[F_W-1:0] = f_lat_q;
         `MGP_OFF_G_DIR: rdata_d[G_W-1:0] = g_dir_q;
         `MGP_OFF_G_PIN: rdata_d[G_W-1:0] = g_pin_in;
         `MGP_OFF_G_LAT: rdata_d[G_W-1:0] = g_lat_q;
         `MGP_OFF_H_DIR: rdata_d[H_W-1:0] = h_dir_q;
         `MGP_OFF_H_PIN: rdata_d[H_W-1:0] = h_digital_in;
         `MGP_OFF_H_LAT: rdata_d[H_W-1:0] = h_lat_q;
         `MGP_OFF_ACFG: rdata_d[5:0] = acfg_q;
         `MGP_OFF_CMP: rdata_d = {comparator_two_result, comparator_one_result, cmp_q};
         `MGP_OFF_CIO: rdata_d[7:4] = cio_q;
         default: rdata_d = `MGP_RD_NONE;
      endcase
   end

   // data held only in the cycle after the strobe, zero otherwise
   always @(posedge clock or negedge any_rst_b)
   begin
      if (!any_rst_b)
      begin
         rdata_q <= `MGP_RD_NONE;
      end
      else if (reg_rd)
      begin
         rdata_q <= rdata_d;
      end
      else
      begin
         rdata_q <= `MGP_RD_NONE;
      end
   end

   assign reg_rdata = rdata_q;

   // ----------------------------------------
   // control outputs to peripherals
   // ----------------------------------------
   assign comparator_mode = cmp_q[2:0];
   assign analog_config_out = acfg_q;
   assign can_pin_control_out = cio_q;

endmodule

// *** testbench/mgp_ports_monitor.sv ***
// checker for register and pin behaviour of the port block
// assumes binding to the block top; all pins are seen at its ports
module mgp_ports_monitor #(parameter F_W = 8, parameter G_W = 5, parameter H_W = 8) (
   // clock and resets
   input wire logic clock,
   input wire logic rst_b,
   input wire logic por_b,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   // pins
   input wire logic [F_W-1:0] f_pin_oe,
   input wire logic [G_W-1:0] g_pin_in,
   input wire logic [G_W-1:0] g_pin_out,
   input wire logic [G_W-1:0] g_pin_oe,
   input wire logic [H_W-1:0] h_pin_oe,
   // peripherals
   input wire logic [5:0] analog_config_out,
   input wire logic can_enable,
   input wire logic can_transmit_out,
   input wire logic can_receive_in
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [4:0] dir_q;
   logic [4:0] lat_q;
   wire any_rst_b = rst_b & por_b;
   // shadows of what software wrote, so pins are judged without the body
   always @(posedge clock or negedge rst_b or negedge por_b)
   begin
      if (!rst_b || !por_b)
      begin
         dir_q <= 5'h1f;
         if (!por_b)
            lat_q <= 5'h00;
      end
      else if (reg_wr && reg_addr == 8'h03)
         dir_q <= reg_wdata[4:0];
      else if (reg_wr && (reg_addr == 8'h04 || reg_addr == 8'h05))
         lat_q <= reg_wdata[4:0];
   end
   default clocking @(posedge clock); endclocking
   default disable iff (!any_rst_b);
   sequence rd_lat_s;
      reg_rd && reg_addr == 8'h05;
   endsequence
   sequence rd_pin_s;
      reg_rd && reg_addr == 8'h04;
   endsequence
   chk_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
      else $error("read data not idle");
   chk_latch_read: assert property (rd_lat_s |=> reg_rdata == {3'h0, lat_q})
      else $error("latch read wrong");
   chk_pin_read: assert property (rd_pin_s |=> reg_rdata == {3'h0, $past(g_pin_in)})
      else $error("pin read wrong");
   chk_dir_float: assert property (g_pin_oe == (~dir_q & {2'b11, !can_enable, 2'b11}))
      else $error("second port enable wrong");
   chk_latch_drive: assert property (g_pin_oe[4:3] == 2'b11 |->
      g_pin_out[4:3] == lat_q[4:3])
      else $error("second port drive wrong");
   chk_can_tx: assert property (g_pin_oe[0] |->
      g_pin_out[0] == (can_enable ? can_transmit_out : lat_q[0]))
      else $error("transmit pin wrong");
   chk_can_rx: assert property (can_receive_in == (can_enable ? g_pin_in[2] : 1'b1))
      else $error("receive path wrong");
   chk_dir_reset: assert property ($rose(any_rst_b) |->
      !(|{f_pin_oe, g_pin_oe, h_pin_oe}))
      else $error("pins driven after reset");
   chk_analog_idle: assert property (analog_config_out[3:0] == 4'h0 |->
      {f_pin_oe[6:3], f_pin_oe[0], h_pin_oe[7:4]} == 9'h000)
      else $error("analog pin driven");
endmodule
bind mgp_ports mgp_ports_monitor #(.F_W(F_W), .G_W(G_W), .H_W(H_W)) u_mon (.*);

// *** testbench/mgp_pins_model.sv ***
// pad model: resolves each pin from block drive and outside level
// assumes a weak outside source, so an enabled block driver wins
module mgp_pins_model #(parameter W = 8) (
   // block side
   input wire logic [W-1:0] pin_out,
   input wire logic [W-1:0] pin_oe,
   // outside world
   input wire logic [W-1:0] ext_level,
   output wire logic [W-1:0] pin_in
);
   timeunit 1ns;
   timeprecision 100ps;
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule

// *** testbench/test_mgp_ports.sv ***
// self-checking bench for the three-port block
// assumes the register port answers reads one cycle after the strobe
`define CHK(a, e) \
   begin \
      comparisons++; \
      if ((a) !== (e)) \
      begin \
         n_mismatch++; \
         $display("[ERR] %0t got %h expected %h", $time, a, e); \
      end \
   end
module test_mgp_ports;
   timeunit 1ns;
   timeprecision 100ps;
   logic clock, rst_b, por_b, reg_wr, reg_rd;
   logic [7:0] reg_addr, reg_wdata, reg_rdata;
   logic [7:0] f_out, f_oe, f_in, f_ext, h_out, h_oe, h_in, h_ext;
   logic [4:0] g_out, g_oe, g_in, g_ext;
   logic cmp_one, cmp_two, cmp_ref, can_en, can_tx, can_tx_n, can_bclk, can_rx;
   logic [2:0] cmp_mode;
   logic [5:0] acfg_out;
   logic [3:0] cio_out;
   int n_mismatch = 0;
   int comparisons = 0;
   mgp_ports dut (.clock(clock), .rst_b(rst_b), .por_b(por_b), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .f_pin_in(f_in), .f_pin_out(f_out), .f_pin_oe(f_oe), .g_pin_in(g_in),
      .g_pin_out(g_out), .g_pin_oe(g_oe), .h_pin_in(h_in), .h_pin_out(h_out),
      .h_pin_oe(h_oe), .comparator_one_result(cmp_one), .comparator_two_result(cmp_two),
      .comparator_reference_out(cmp_ref), .comparator_mode(cmp_mode),
      .analog_config_out(acfg_out),
      .can_enable(can_en), .can_transmit_out(can_tx), .can_complement_transmit_out(can_tx_n),
      .can_bit_clock(can_bclk), .can_receive_in(can_rx), .can_pin_control_out(cio_out));
   mgp_pins_model #(.W(8)) u_f (.pin_out(f_out), .pin_oe(f_oe), .ext_level(f_ext), .pin_in(f_in));
   mgp_pins_model #(.W(5)) u_g (.pin_out(g_out), .pin_oe(g_oe), .ext_level(g_ext), .pin_in(g_in));
   mgp_pins_model #(.W(8)) u_h (.pin_out(h_out), .pin_oe(h_oe), .ext_level(h_ext), .pin_in(h_in));
   // ------------------------------
   // bus tasks
   // ------------------------------
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clock);
      reg_wr <= 1'b0;
      @(negedge clock);
   endtask
   task rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge clock);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clock);
      reg_rd <= 1'b0;
      @(negedge clock);
      `CHK(reg_rdata, e)
   endtask
   task test_done;
      if (n_mismatch == 0 && comparisons > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   initial
   begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   // whole sequence is about a hundred cycles; this span is far beyond it
   initial
   begin
      #20000;
      n_mismatch++;
      test_done;
   end
   initial
   begin
      {rst_b, por_b, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
      {cmp_one, cmp_two, cmp_ref, can_en, can_tx, can_tx_n, can_bclk} = '0;
      f_ext = 8'hff;
      g_ext = 5'h1b;
      h_ext = 8'hff;
      repeat (8) @(posedge clock);
      rst_b <= 1'b1;
      por_b <= 1'b1;
      rd(8'h00, 8'hff);
      rd(8'h03, 8'h1f);
      rd(8'h06, 8'hff);
      rd(8'h05, 8'h00);
      rd(8'h0c, 8'h00);
      rd(8'h01, 8'h80);
      rd(8'h07, 8'h0f);
      wr(8'h09, 8'h01);
      rd(8'h07, 8'h8f);
      `CHK(acfg_out, 6'h01)
      wr(8'h0a, 8'h07);
      wr(8'h09, 8'h0f);
      `CHK(cmp_mode, 3'h7)
      rd(8'h07, 8'hff);
      wr(8'h00, 8'hcf);
      wr(8'h02, 8'haa);
      `CHK(f_oe, 8'h30)
      `CHK(f_out & 8'h30, 8'h20)
      rd(8'h01, 8'hef);
      rd(8'h02, 8'haa);
      @(posedge clock);
      cmp_two <= 1'b1;
      wr(8'h0a, 8'h03);
      rd(8'h0a, 8'h83);
      wr(8'h00, 8'h00);
      `CHK(f_oe, 8'h87)
      `CHK(f_out[2:1], 2'b01)
      wr(8'h0a, 8'h07);
      @(posedge clock);
      cmp_ref <= 1'b1;
      rd(8'h01, 8'h8a);
      `CHK(f_oe, 8'hdf)
      wr(8'h04, 8'h15);
      rd(8'h05, 8'h15);
      wr(8'h05, 8'h0a);
      rd(8'h05, 8'h0a);
      wr(8'h03, 8'h00);
      `CHK(g_oe, 5'h1f)
      `CHK(g_out, 5'h0a)
      rd(8'h04, 8'h0a);
      wr(8'h03, 8'hff);
      rd(8'h03, 8'h1f);
      `CHK(g_oe, 5'h00)
      rd(8'h04, 8'h1b);
      // warm reset must keep latches but restore directions
      wr(8'h06, 8'h00);
      wr(8'h08, 8'h5a);
      `CHK(h_oe, 8'hff)
      `CHK(h_out, 8'h5a)
      @(posedge clock);
      rst_b <= 1'b0;
      repeat (2) @(posedge clock);
      rst_b <= 1'b1;
      rd(8'h05, 8'h0a);
      rd(8'h08, 8'h5a);
      rd(8'h06, 8'hff);
      rd(8'h09, 8'h00);
      `CHK(h_oe, 8'h00)
      wr(8'h03, 8'h04);
      @(posedge clock);
      can_en <= 1'b1;
      can_tx <= 1'b1;
      can_bclk <= 1'b1;
      g_ext <= 5'h04;
      wr(8'h0b, 8'hcf);
      rd(8'h0b, 8'hc0);
      `CHK(cio_out, 4'hc)
      `CHK(g_out[0], 1'b1)
      `CHK(g_oe, 5'h1b)
      `CHK(can_rx, 1'b1)
      `CHK(g_out[1], 1'b1)
      wr(8'h0b, 8'h40);
      `CHK(g_out[1], 1'b0)
      @(posedge clock);
      g_ext <= 5'h00;
      @(negedge clock);
      `CHK(can_rx, 1'b0)
      @(posedge clock);
      can_en <= 1'b0;
      @(negedge clock);
      `CHK(can_rx, 1'b1)
      `CHK(g_out[1:0], 2'b10)
      @(posedge clock);
      por_b <= 1'b0;
      @(posedge clock);
      por_b <= 1'b1;
      rd(8'h05, 8'h00);
      test_done;
   end
endmodule
